// ---- hdl/aod_decoder.sv ----
`timescale 1ns/1ps
`include "aod_cfg.svh"
module aod_decoder (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_resetn,
   // Byte stream from prefetch
   input wire logic i_byte_valid,
   input wire logic [7:0] i_byte,
   // Decoded instruction
   output logic o_done,
   output logic o_unknown,
   output logic o_busy,
   output aod_pkg::aod_instr_t o_instr
);
   typedef enum logic [3:0] {
      AOD_ST_OPC = 4'h1,
      AOD_ST_MODRM = 4'h2,
      AOD_ST_DLO = 4'h4,
      AOD_ST_DHI = 4'h8
   } aod_state_t;

   // Matches a byte against a pattern under a mask
   function automatic logic aod_match(input logic [7:0] b, input logic [7:0] pat, input logic [7:0] msk);
      aod_match = ((b & msk) == pat);
   endfunction : aod_match

   aod_state_t state_q, state_d;
   aod_pkg::aod_instr_t cur_q, cur_d;
   logic [7:0] opc_q, opc_d;
   logic done_q, unk_q, done_d, unk_d;
   logic hold_we;

   // Opcode decoding
   wire logic m_adc_rm = aod_match(i_byte, `AOD_OPC_ADC_RM, `AOD_MASK_DW);
   wire logic m_adc_acc = aod_match(i_byte, `AOD_OPC_ADC_ACC, `AOD_MASK_W);
   wire logic m_sub_rm = aod_match(i_byte, `AOD_OPC_SUB_RM, `AOD_MASK_DW);
   wire logic m_sub_acc = aod_match(i_byte, `AOD_OPC_SUB_ACC, `AOD_MASK_W);
   wire logic m_sbb_rm = aod_match(i_byte, `AOD_OPC_SBB_RM, `AOD_MASK_DW);
   wire logic m_sbb_acc = aod_match(i_byte, `AOD_OPC_SBB_ACC, `AOD_MASK_W);
   wire logic m_imm = aod_match(i_byte, `AOD_OPC_IMM_GRP, `AOD_MASK_DW);
   wire logic m_incdec = aod_match(i_byte, `AOD_OPC_INCDEC, `AOD_MASK_W);
   wire logic m_inc_reg = aod_match(i_byte, `AOD_OPC_INC_REG, `AOD_MASK_REG);
   wire logic m_dec_reg = aod_match(i_byte, `AOD_OPC_DEC_REG, `AOD_MASK_REG);
   wire logic m_aaa = (i_byte == `AOD_OPC_AAA);
   wire logic m_daa = (i_byte == `AOD_OPC_DAA);
   wire logic m_rm = m_adc_rm | m_sub_rm | m_sbb_rm;
   wire logic m_acc = m_adc_acc | m_sub_acc | m_sbb_acc;
   wire logic m_one = m_inc_reg | m_dec_reg | m_aaa | m_daa;
   wire logic m_any = m_rm | m_acc | m_imm | m_incdec | m_one;

   // Addressing byte field and second-byte decisions from the latched opcode
   wire logic [2:0] op_fld = i_byte[`AOD_FLD_LSB+2:`AOD_FLD_LSB];
   wire logic opc_w = opc_q[`AOD_BIT_W];
   wire logic opc_s = opc_q[`AOD_BIT_S];
   wire logic imm_grp = aod_match(opc_q, `AOD_OPC_IMM_GRP, `AOD_MASK_DW);
   wire logic incdec_grp = aod_match(opc_q, `AOD_OPC_INCDEC, `AOD_MASK_W);
   wire logic imm_two = ({opc_s, opc_w} == 2'b01);
   wire logic fld_ok = imm_grp ? (op_fld == `AOD_FLD_ADC || op_fld == `AOD_FLD_SUB || op_fld == `AOD_FLD_SBB)
      : incdec_grp ? (op_fld == `AOD_FLD_INC || op_fld == `AOD_FLD_DEC) : 1'b1;
   wire aod_pkg::aod_op_t imm_op = (op_fld == `AOD_FLD_ADC) ? aod_pkg::AOD_OP_ADC
      : (op_fld == `AOD_FLD_SUB) ? aod_pkg::AOD_OP_SUB : aod_pkg::AOD_OP_SBB;
   wire aod_pkg::aod_op_t idc_op = (op_fld == `AOD_FLD_INC) ? aod_pkg::AOD_OP_INC : aod_pkg::AOD_OP_DEC;
   wire aod_pkg::aod_op_t opc_op = (m_adc_rm | m_adc_acc) ? aod_pkg::AOD_OP_ADC
      : (m_sub_rm | m_sub_acc) ? aod_pkg::AOD_OP_SUB
      : (m_sbb_rm | m_sbb_acc) ? aod_pkg::AOD_OP_SBB
      : m_inc_reg ? aod_pkg::AOD_OP_INC
      : m_dec_reg ? aod_pkg::AOD_OP_DEC
      : m_aaa ? aod_pkg::AOD_OP_AAA
      : m_daa ? aod_pkg::AOD_OP_DAA : aod_pkg::AOD_OP_NONE;

   // Sequencer: one byte per accepted beat, no stall needed
   always_comb begin
      state_d = state_q;
      cur_d = cur_q;
      opc_d = opc_q;
      done_d = 1'b0;
      unk_d = 1'b0;
      if (i_byte_valid) begin
         case (state_q)
            AOD_ST_OPC: begin
               opc_d = i_byte;
               cur_d = '0;
               cur_d.op = opc_op;
               cur_d.wide = i_byte[`AOD_BIT_W];
               cur_d.reg_is_dst = m_rm & i_byte[`AOD_BIT_D];
               if (m_one) begin
                  // Single-byte forms finish now
                  cur_d.form = aod_pkg::AOD_FM_REG;
                  cur_d.regf = i_byte[2:0];
                  cur_d.wide = m_inc_reg | m_dec_reg; // Inc/dec register forms are 16-bit; AAA and DAA stay 8-bit
                  done_d = 1'b1;
               end else if (m_acc) begin
                  cur_d.form = aod_pkg::AOD_FM_ACC;
                  state_d = AOD_ST_DLO;
               end else if (m_any) begin
                  cur_d.form = m_imm ? aod_pkg::AOD_FM_IMM_RM : aod_pkg::AOD_FM_RM;
                  state_d = AOD_ST_MODRM;
               end else begin
                  unk_d = 1'b1;
               end
            end
            AOD_ST_MODRM: begin
               cur_d.mode = i_byte[`AOD_MOD_LSB+1:`AOD_MOD_LSB];
               cur_d.regf = op_fld;
               cur_d.rm = i_byte[2:0];
               if (!fld_ok) begin
                  // Other operations of the shared groups belong elsewhere
                  unk_d = 1'b1;
                  state_d = AOD_ST_OPC;
               end else if (imm_grp) begin
                  cur_d.op = imm_op;
                  state_d = AOD_ST_DLO;
               end else begin
                  if (incdec_grp) begin
                     cur_d.op = idc_op;
                  end
                  done_d = 1'b1;
                  state_d = AOD_ST_OPC;
               end
            end
            AOD_ST_DLO: begin
               cur_d.imm = {8'h00, i_byte};
               cur_d.imm_cnt = 2'h1;
               if (imm_grp ? imm_two : opc_w) begin
                  state_d = AOD_ST_DHI;
               end else begin
                  // Sign-extended byte with s=1 w=1 stays raw; execution extends it
                  done_d = 1'b1;
                  state_d = AOD_ST_OPC;
               end
            end
            AOD_ST_DHI: begin
               cur_d.imm[15:8] = i_byte;
               cur_d.imm_cnt = 2'h2;
               done_d = 1'b1;
               state_d = AOD_ST_OPC;
            end
            default: begin
               state_d = AOD_ST_OPC;
            end
         endcase
      end
   end

   // State registers
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         state_q <= AOD_ST_OPC;
         cur_q <= '0;
         opc_q <= 8'h00;
         done_q <= 1'b0;
         unk_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cur_q <= cur_d;
         opc_q <= opc_d;
         done_q <= done_d;
         unk_q <= unk_d;
      end
   end

   // Busy mirrors the sequencer, kept as its own flop for a clean output
   logic busy_q;
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (state_d != AOD_ST_OPC);
      end
   end

   assign hold_we = done_d;
   assign o_done = done_q;
   assign o_unknown = unk_q;
   assign o_busy = busy_q;

   // Result register holds the last finished instruction
   aod_hold #(
      .WIDTH($bits(aod_pkg::aod_instr_t))
   ) u_hold (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_we(hold_we),
      .i_data(cur_d),
      .o_data(o_instr)
   );
endmodule : aod_decoder

// ---- hdl/aod_cfg.svh ----
`ifndef AOD_CFG_SVH
`define AOD_CFG_SVH
// Opcode patterns; x bits are don't-care within the masks
`define AOD_OPC_ADC_RM 8'h10
`define AOD_OPC_ADC_ACC 8'h14
`define AOD_OPC_SUB_RM 8'h28
`define AOD_OPC_SUB_ACC 8'h2C
`define AOD_OPC_SBB_RM 8'h18
`define AOD_OPC_SBB_ACC 8'h1C
`define AOD_OPC_IMM_GRP 8'h80
`define AOD_OPC_INCDEC 8'hFE
`define AOD_OPC_INC_REG 8'h40
`define AOD_OPC_DEC_REG 8'h48
`define AOD_OPC_AAA 8'h37
`define AOD_OPC_DAA 8'h27
`define AOD_MASK_DW 8'hFC
`define AOD_MASK_W 8'hFE
`define AOD_MASK_REG 8'hF8
// Operation field codes in the addressing byte
`define AOD_FLD_ADC 3'h2
`define AOD_FLD_SBB 3'h3
`define AOD_FLD_SUB 3'h5
`define AOD_FLD_INC 3'h0
`define AOD_FLD_DEC 3'h1
// Field positions
`define AOD_BIT_W 0
`define AOD_BIT_D 1
`define AOD_BIT_S 1
`define AOD_FLD_LSB 3
`define AOD_MOD_LSB 6
`endif

// ---- hdl/aod_pkg.sv ----
package aod_pkg;
   typedef enum logic [3:0] {
      AOD_OP_NONE = 4'h0,
      AOD_OP_ADC = 4'h1,
      AOD_OP_INC = 4'h2,
      AOD_OP_AAA = 4'h3,
      AOD_OP_DAA = 4'h4,
      AOD_OP_SUB = 4'h5,
      AOD_OP_SBB = 4'h6,
      AOD_OP_DEC = 4'h7
   } aod_op_t;
   typedef enum logic [1:0] {
      AOD_FM_RM = 2'h0,
      AOD_FM_IMM_RM = 2'h1,
      AOD_FM_ACC = 2'h2,
      AOD_FM_REG = 2'h3
   } aod_form_t;
   typedef struct packed {
      aod_op_t op;
      aod_form_t form;
      logic wide;
      logic reg_is_dst;
      logic [1:0] mode;
      logic [2:0] regf;
      logic [2:0] rm;
      logic [15:0] imm;
      logic [1:0] imm_cnt;
   } aod_instr_t;
endpackage : aod_pkg

// ---- hdl/aod_hold.sv ----
`timescale 1ns/1ps
// Holds the decoded instruction; output comes straight from a register
module aod_hold #(
   parameter int WIDTH = 34
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_resetn,
   // Write side
   input wire logic i_we,
   input wire logic [WIDTH-1:0] i_data,
   // Read side
   output logic [WIDTH-1:0] o_data
);
   // Capture on write, clear on reset
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         o_data <= '0;
      end else if (i_we) begin
         o_data <= i_data;
      end
   end
endmodule : aod_hold

// ---- verif/aod_decoder_properties.sv ----
`timescale 1ns/1ps
// Watches the decoder ports; an opcode is taken only while no instruction is open
module aod_decoder_chk (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_resetn,
   // Byte stream
   input wire logic i_byte_valid,
   input wire logic [7:0] i_byte,
   // Decoded result
   input wire logic o_done,
   input wire logic o_unknown,
   input wire logic o_busy,
   input aod_pkg::aod_instr_t o_instr
);
   logic opc_w;
   logic rmop_w;
   logic [2:0] reg_q;
   // Opcode slot and the register-with-register/memory opcodes
   assign opc_w = i_byte_valid && !o_busy;
   assign rmop_w = i_byte[7:2] inside {6'h04, 6'h06, 6'h0A};
   // Register number of the last byte, kept for the one-byte forms
   always_ff @(posedge i_mclk) begin
      reg_q <= i_byte[2:0];
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   aaa_single_a: assert property (opc_w && i_byte == 8'h37 |=> o_done && !o_busy && o_instr.op == 4'h3)
      else $error("ascii adjust not decoded in one byte");
   daa_single_a: assert property (opc_w && i_byte == 8'h27 |=> o_done && !o_busy && o_instr.op == 4'h4)
      else $error("decimal adjust not decoded in one byte");
   inc_reg_a: assert property (opc_w && i_byte[7:3] == 5'h08 |=> o_done && o_instr.op == 4'h2 && o_instr.regf == reg_q)
      else $error("increment register form wrong");
   dec_reg_a: assert property (opc_w && i_byte[7:3] == 5'h09 |=> o_done && o_instr.op == 4'h7 && o_instr.regf == reg_q)
      else $error("decrement register form wrong");
   modrm_only_a: assert property (opc_w && rmop_w ##1 i_byte_valid |=> o_done && o_instr.imm_cnt == 2'h0)
      else $error("register form did not end after addressing byte");
   imm_field_a: assert property (o_done && o_instr.form == 2'h1 |-> o_instr.regf == (o_instr.op == 4'h1 ? 3'h2 :
      o_instr.op == 4'h6 ? 3'h3 : 3'h5)) else $error("immediate group field and operation disagree");
   acc_count_a: assert property (o_done && o_instr.form == 2'h2 |-> o_instr.imm_cnt == {o_instr.wide, !o_instr.wide})
      else $error("accumulator data count wrong");
   acc_busy_a: assert property (opc_w && i_byte[7:1] == 7'h0A |=> o_busy && !o_done)
      else $error("accumulator form ended at opcode");
   incdec_fld_a: assert property (o_done && o_instr.form != 2'h3 && o_instr.op inside {4'h2, 4'h7} |->
      o_instr.regf == {2'h0, o_instr.op == 4'h7}) else $error("increment or decrement field wrong");
   acc_wide_c: cover property (o_done && o_instr.form == 2'h2 && o_instr.imm_cnt == 2'h2);
   imm_two_c: cover property (o_done && o_instr.form == 2'h1 && o_instr.imm_cnt == 2'h2);
   unknown_c: cover property (o_unknown);
endmodule : aod_decoder_chk

bind aod_decoder aod_decoder_chk u_chk (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_byte_valid(i_byte_valid),
   .i_byte(i_byte), .o_done(o_done), .o_unknown(o_unknown), .o_busy(o_busy), .o_instr(o_instr));

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   logic i_mclk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_byte_valid = 1'b0;
   logic [7:0] i_byte = 8'h00;
   logic o_done;
   logic o_unknown;
   logic o_busy;
   aod_pkg::aod_instr_t o_instr;
   aod_pkg::aod_instr_t got;
   aod_pkg::aod_instr_t e;
   int n_mismatch = 0;
   int checks_done = 0;
   always #25 i_mclk = ~i_mclk;
   aod_decoder dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_byte_valid(i_byte_valid), .i_byte(i_byte),
      .o_done(o_done), .o_unknown(o_unknown), .o_busy(o_busy), .o_instr(o_instr));
   // One comparison; ok comes from a case equality so unknowns fail
   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : chk
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   function automatic aod_pkg::aod_instr_t mk(aod_pkg::aod_op_t op, aod_pkg::aod_form_t f, logic w, logic d,
      logic [7:0] m, logic [15:0] imm, logic [1:0] c);
      mk = '{op, f, w, d, m[7:6], m[5:3], m[2:0], imm, c};
   endfunction : mk
   // Sends n bytes, first in the low byte, idle cycle before byte gap; cmp 2 full, 1 without modrm fields
   task automatic run(input logic [31:0] b, input int n, input int gap, input logic unk, input int cmp);
      for (int j = 0; j < n; j++) begin
         if (j == gap) begin
            @(posedge i_mclk);
            i_byte_valid <= 1'b0;
         end
         @(posedge i_mclk);
         i_byte_valid <= 1'b1;
         i_byte <= b[8*j +: 8];
         #1;
         if (j > 0) chk(o_busy === 1'b1, "busy low mid instruction");
      end
      @(posedge i_mclk);
      i_byte_valid <= 1'b0;
      #1;
      chk(o_done === !unk && o_unknown === unk && o_busy === 1'b0, "wrong completion");
      got = o_instr;
      if (cmp == 1) {got.mode, got.regf, got.rm} = 8'h00;
      if (cmp > 0) chk(got === e, "decoded fields differ");
   endtask : run
   task automatic t_single;
      run(32'h37, 1, 9, 1'b0, 0);
      chk(o_instr.op === aod_pkg::AOD_OP_AAA && o_instr.wide === 1'b0, "ascii adjust");
      run(32'h27, 1, 9, 1'b0, 0);
      chk(o_instr.op === aod_pkg::AOD_OP_DAA && o_instr.imm_cnt === 2'h0, "decimal adjust");
      for (int r = 0; r < 8; r++) begin
         run(32'h40 + r, 1, 9, 1'b0, 0);
         chk(o_instr.op === aod_pkg::AOD_OP_INC && o_instr.regf === 3'(r), "inc register");
         run(32'h48 + r, 1, 9, 1'b0, 0);
         chk(o_instr.op === aod_pkg::AOD_OP_DEC && o_instr.wide === 1'b1, "dec register");
      end
      $display("single byte forms done");
   endtask : t_single
   // Two direction and width pairings per operation, all four covered across the three operations
   task automatic t_rm;
      logic [7:0] opc[6] = '{8'h10, 8'h13, 8'h29, 8'h2A, 8'h18, 8'h1B};
      aod_pkg::aod_op_t opl[3] = '{aod_pkg::AOD_OP_ADC, aod_pkg::AOD_OP_SUB, aod_pkg::AOD_OP_SBB};
      for (int k = 0; k < 6; k++) begin
         e = mk(opl[k/2], aod_pkg::AOD_FM_RM, opc[k][0], opc[k][1], 8'h91 + 8'(k * 9), 16'h0000, 2'h0);
         run({16'h0, e.mode, e.regf, e.rm, opc[k]}, 2, k % 2 + 1, 1'b0, 2);
      end
      run(32'h47FF, 2, 9, 1'b0, 0);
      chk(o_instr.op === aod_pkg::AOD_OP_INC && o_instr.wide === 1'b1, "inc memory");
      run(32'h0DFE, 2, 9, 1'b0, 0);
      chk(o_instr.op === aod_pkg::AOD_OP_DEC && o_instr.wide === 1'b0, "dec memory");
      $display("register forms done");
   endtask : t_rm
   task automatic t_imm;
      e = mk(aod_pkg::AOD_OP_ADC, aod_pkg::AOD_FM_IMM_RM, 1'b0, 1'b0, 8'hD1, 16'h00AB, 2'h1);
      run(32'hABD180, 3, 9, 1'b0, 2);
      e = mk(aod_pkg::AOD_OP_SUB, aod_pkg::AOD_FM_IMM_RM, 1'b1, 1'b0, 8'hAA, 16'h1234, 2'h2);
      run(32'h1234AA81, 4, 2, 1'b0, 2);
      e = mk(aod_pkg::AOD_OP_SBB, aod_pkg::AOD_FM_IMM_RM, 1'b1, 1'b0, 8'h5E, 16'h007F, 2'h1);
      run(32'h7F5E83, 3, 9, 1'b0, 2);
      $display("immediate forms done");
   endtask : t_imm
   task automatic t_acc;
      e = mk(aod_pkg::AOD_OP_ADC, aod_pkg::AOD_FM_ACC, 1'b1, 1'b0, 8'h00, 16'h1234, 2'h2);
      run(32'h123415, 3, 9, 1'b0, 1);
      e = mk(aod_pkg::AOD_OP_SUB, aod_pkg::AOD_FM_ACC, 1'b0, 1'b0, 8'h00, 16'h0080, 2'h1);
      run(32'h802C, 2, 9, 1'b0, 1);
      e = mk(aod_pkg::AOD_OP_SBB, aod_pkg::AOD_FM_ACC, 1'b1, 1'b0, 8'h00, 16'hABCD, 2'h2);
      run(32'hABCD1D, 3, 1, 1'b0, 1);
      $display("accumulator forms done");
   endtask : t_acc
   // Outside the group, and a bad field, must leave the next opcode intact
   task automatic t_bad;
      run(32'h00, 1, 9, 1'b1, 0);
      run(32'hD0FE, 2, 9, 1'b1, 0);
      run(32'h37, 1, 9, 1'b0, 0);
      $display("unknown codes done");
   endtask : t_bad
   initial begin
      repeat (10) @(posedge i_mclk);
      i_resetn <= 1'b1;
      #1;
      chk(o_done === 1'b0 && o_busy === 1'b0 && o_unknown === 1'b0, "outputs not idle after reset");
      chk(o_instr === '0, "result not cleared by reset");
      t_single();
      t_rm();
      t_imm();
      t_acc();
      t_bad();
      give_verdict();
   end
endmodule : testbench
